// >>> usd_pkg.sv
// constants, state types and helpers for the serial data path
package usd_pkg;

    localparam int         OVERSAMPLE = 16;
    localparam logic [3:0] OS_MID     = 4'h7;
    localparam logic [3:0] OS_LAST    = 4'hF;
    localparam int         SYNC_DEPTH = 2;

    localparam logic [2:0] CSZ_5 = 3'h0;
    localparam logic [2:0] CSZ_6 = 3'h1;
    localparam logic [2:0] CSZ_7 = 3'h2;
    localparam logic [2:0] CSZ_8 = 3'h3;
    localparam logic [2:0] CSZ_9 = 3'h7;

    localparam logic [3:0] NB_5 = 4'h5;
    localparam logic [3:0] NB_6 = 4'h6;
    localparam logic [3:0] NB_7 = 4'h7;
    localparam logic [3:0] NB_8 = 4'h8;
    localparam logic [3:0] NB_9 = 4'h9;

    localparam logic [8:0] DATA_RST = 9'h000;

    typedef enum logic [2:0] {
        TX_IDLE  = 3'h0,
        TX_START = 3'h1,
        TX_DATA  = 3'h2,
        TX_PAR   = 3'h3,
        TX_STOP  = 3'h4,
        TX_FIN   = 3'h5
    } usd_tx_state_t;

    typedef enum logic [2:0] {
        RX_IDLE  = 3'h0,
        RX_START = 3'h1,
        RX_DATA  = 3'h2,
        RX_PAR   = 3'h3,
        RX_STOP  = 3'h4
    } usd_rx_state_t;

    // reserved size codes fall back to eight bits
    function automatic logic [3:0] usd_nbits(input logic [2:0] csz);
        case (csz)
            CSZ_5:   return NB_5;
            CSZ_6:   return NB_6;
            CSZ_7:   return NB_7;
            CSZ_9:   return NB_9;
            default: return NB_8;
        endcase
    endfunction : usd_nbits

    function automatic logic [8:0] usd_mask(input logic [3:0] nb);
        logic [9:0] m;
        m = (10'h001 << nb) - 10'h001;
        return m[8:0];
    endfunction : usd_mask

endpackage : usd_pkg

// >>> usd_line_sync.sv
// pin synchronisers and bit-rate enables for the serial data path
`timescale 1ns/1ps
module usd_line_sync (
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic sync_mode,
    input  wire logic xck_polarity,
    input  wire logic baud_os_tick,
    input  wire logic xck_pin_in,
    input  wire logic rxd_pin_in,
    output logic      rxd_sync,
    output logic      tx_bit_en,
    output logic      rx_sync_sample
);
    logic [1:0] pin_in;
    logic [1:0] s1_ff;
    logic [1:0] s2_ff;
    logic       xck_prev_ff;
    logic       nxt_xck_prev;
    logic [3:0] os_cnt_ff;
    logic [3:0] nxt_os_cnt;
    logic       rise;
    logic       fall;

    assign pin_in = {xck_pin_in, rxd_pin_in};

    // two flops per pin; only stage two is looked at
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_sync
            always_ff @(posedge clk or negedge resetn) begin
                if (!resetn) begin
                    s1_ff[g] <= 1'b1;
                    s2_ff[g] <= 1'b1;
                end else begin
                    s1_ff[g] <= pin_in[g];
                    s2_ff[g] <= s1_ff[g];
                end
            end
        end
    endgenerate

    always_comb begin
        nxt_xck_prev = s2_ff[1];
        nxt_os_cnt   = os_cnt_ff;
        if (baud_os_tick) begin
            nxt_os_cnt = os_cnt_ff + 4'h1;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            xck_prev_ff <= 1'b1;
            os_cnt_ff   <= 4'h0;
        end else begin
            xck_prev_ff <= nxt_xck_prev;
            os_cnt_ff   <= nxt_os_cnt;
        end
    end

    // synchronisation adds two cycles before an edge is seen, so xck must stay below clk/4
    assign rise     = s2_ff[1] & ~xck_prev_ff;
    assign fall     = ~s2_ff[1] & xck_prev_ff;
    assign rxd_sync = s2_ff[0];
    // sync mode: change on one xck edge, sample on the other [R2] [R16]
    assign tx_bit_en = sync_mode ? (xck_polarity ? fall : rise)
                                 : (baud_os_tick && os_cnt_ff == usd_pkg::OS_LAST);
    assign rx_sync_sample = sync_mode & (xck_polarity ? rise : fall);

endmodule : usd_line_sync

// >>> usd_datapath.sv
// transmit and receive data path of the serial port
//
// Summary of operation
// R1 - tx enable takes over the transmit pin
// R2 - sync mode shifts tx on xck
// R3 - write loads buffer, moved when shifter free
// R4 - unused upper bits ignored for 5-8
// R5 - software sets ninth bit before low byte
// R6 - empty flag mirrors transmit buffer state
// R7 - data write clears empty flag
// R8 - empty interrupt held while flag set
// R9 - handler writes data or masks interrupt
// R10 - complete flag set when frame and buffer done
// R11 - complete flag cleared by service or one
// R12 - complete interrupt requested when flag sets
// R13 - parity inserted before first stop bit
// R14 - disable waits for shifter and buffer empty
// R15 - rx enable takes over receive pin
// R16 - sync mode samples rx on xck
// R17 - frame begins only on valid start
// R18 - frame ends at first stop bit
// R19 - first stop moves data to buffer
// R20 - unused upper received bits read zero
// R21 - software writes zero to empty flag
// R22 - software configures format before sending
// R23 - start low, lsb first, parity, stop high
// R24 - parity is xor of data, inverted odd
// R25 - rx complete flag shows unread data
// R26 - idle enabled transmitter drives line high
`timescale 1ns/1ps
module usd_datapath (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       baud_os_tick,
    input  wire logic       sync_mode,
    input  wire logic       xck_polarity,
    input  wire logic       transmitter_enable_bit,
    input  wire logic       receiver_enable_bit,
    input  wire logic [2:0] character_size_field,
    input  wire logic       parity_enable_bit,
    input  wire logic       parity_odd_select,
    input  wire logic       stop_bits_select,
    input  wire logic       buffer_empty_irq_enable,
    input  wire logic       tx_complete_irq_enable,
    input  wire logic       tx_ninth_bit,
    input  wire logic       data_wr,
    input  wire logic [7:0] data_wdata,
    input  wire logic       data_rd,
    input  wire logic       tx_complete_clear_wr,
    input  wire logic       tx_complete_irq_ack,
    input  wire logic       xck_pin_in,
    input  wire logic       rxd_pin_in,
    output logic            txd_out,
    output logic            txd_oe,
    output logic            rxd_override,
    output logic            tx_buffer_empty_flag,
    output logic            tx_complete_flag,
    output logic            rx_complete_flag,
    output logic            buffer_empty_irq,
    output logic            tx_complete_irq,
    output logic [7:0]      rx_data,
    output logic            rx_ninth_bit
);
    logic                  rxd_s;
    logic                  tx_bit_en;
    logic                  rx_sync_sample;
    logic [3:0]            nbits;
    logic [8:0]            dmask;

    usd_pkg::usd_tx_state_t tx_state_ff, nxt_tx_state;
    logic [8:0]            tbuf_ff, nxt_tbuf;
    logic                  tfull_ff, nxt_tfull;
    logic [8:0]            tsh_ff, nxt_tsh;
    logic                  tpar_ff, nxt_tpar;
    logic [3:0]            tidx_ff, nxt_tidx;
    logic                  tstop2_ff, nxt_tstop2;
    logic                  txd_ff, nxt_txd;
    logic                  txoe_ff, nxt_txoe;
    logic                  empty_ff, nxt_empty;
    logic                  txc_ff, nxt_txc;
    logic                  eirq_ff, nxt_eirq;
    logic                  cirq_ff, nxt_cirq;
    logic                  tx_done;

    usd_pkg::usd_rx_state_t rx_state_ff, nxt_rx_state;
    logic [8:0]            rsh_ff, nxt_rsh;
    logic [3:0]            ridx_ff, nxt_ridx;
    logic [3:0]            ros_ff, nxt_ros;
    logic [8:0]            rbuf_ff, nxt_rbuf;
    logic                  rxc_ff, nxt_rxc;
    logic                  rxov_ff, nxt_rxov;
    logic                  rsample;

    usd_line_sync u_sync (
        .clk            (clk),
        .resetn         (resetn),
        .sync_mode      (sync_mode),
        .xck_polarity   (xck_polarity),
        .baud_os_tick   (baud_os_tick),
        .xck_pin_in     (xck_pin_in),
        .rxd_pin_in     (rxd_pin_in),
        .rxd_sync       (rxd_s),
        .tx_bit_en      (tx_bit_en),
        .rx_sync_sample (rx_sync_sample)
    );

    assign nbits = usd_pkg::usd_nbits(character_size_field);
    assign dmask = usd_pkg::usd_mask(nbits);

    // ---------------- transmitter ----------------
    always_comb begin
        nxt_tx_state = tx_state_ff;
        nxt_tbuf     = tbuf_ff;
        nxt_tfull    = tfull_ff;
        nxt_tsh      = tsh_ff;
        nxt_tpar     = tpar_ff;
        nxt_tidx     = tidx_ff;
        nxt_tstop2   = tstop2_ff;
        nxt_txd      = txd_ff;
        tx_done      = 1'b0;
        unique case (tx_state_ff)
            usd_pkg::TX_IDLE: begin
                nxt_txd = 1'b1;                                     // [R26]
                if (tfull_ff) begin                                 // [R3]
                    nxt_tx_state = usd_pkg::TX_START;
                end
            end
            usd_pkg::TX_START: begin
                if (tx_bit_en) begin
                    nxt_txd      = 1'b0;                            // [R23]
                    nxt_tx_state = usd_pkg::TX_DATA;
                end
            end
            usd_pkg::TX_DATA: begin
                if (tx_bit_en) begin
                    nxt_txd  = tsh_ff[0];                           // [R23]
                    nxt_tsh  = {1'b0, tsh_ff[8:1]};
                    nxt_tidx = tidx_ff + 4'h1;
                    if (tidx_ff + 4'h1 == nbits) begin
                        nxt_tx_state = parity_enable_bit ? usd_pkg::TX_PAR
                                                         : usd_pkg::TX_STOP;
                    end
                end
            end
            usd_pkg::TX_PAR: begin
                if (tx_bit_en) begin
                    nxt_txd      = tpar_ff;                         // [R13]
                    nxt_tx_state = usd_pkg::TX_STOP;
                end
            end
            usd_pkg::TX_STOP: begin
                if (tx_bit_en) begin
                    nxt_txd      = 1'b1;                            // [R23]
                    nxt_tstop2   = 1'b0;
                    nxt_tx_state = tstop2_ff ? usd_pkg::TX_STOP : usd_pkg::TX_FIN;
                end
            end
            usd_pkg::TX_FIN: begin
                if (tx_bit_en) begin
                    if (tfull_ff) begin
                        nxt_txd      = 1'b0;                        // [R3]
                        nxt_tx_state = usd_pkg::TX_DATA;
                    end else begin
                        nxt_txd      = 1'b1;
                        nxt_tx_state = usd_pkg::TX_IDLE;
                        tx_done      = 1'b1;
                    end
                end
            end
            default: nxt_tx_state = usd_pkg::TX_IDLE;
        endcase
        // shifter load from buffer, idle or straight after the last stop bit
        if (tfull_ff && (tx_state_ff == usd_pkg::TX_IDLE ||
                         (tx_state_ff == usd_pkg::TX_FIN && tx_bit_en))) begin
            nxt_tsh    = tbuf_ff & dmask;                           // [R4]
            nxt_tpar   = (^(tbuf_ff & dmask)) ^ parity_odd_select;  // [R24]
            nxt_tidx   = 4'h0;
            nxt_tstop2 = stop_bits_select;
            nxt_tfull  = 1'b0;
        end
        // a write in the same cycle as the move refills the buffer
        if (data_wr) begin
            nxt_tbuf  = {tx_ninth_bit, data_wdata};                 // [R5]
            nxt_tfull = 1'b1;                                       // [R7]
        end
    end

    always_comb begin
        nxt_empty = ~nxt_tfull;                                     // [R6]
        // pin is held until both shifter and buffer have drained
        nxt_txoe  = transmitter_enable_bit | nxt_tfull |
                    (nxt_tx_state != usd_pkg::TX_IDLE);             // [R1] [R14]
        nxt_txc   = txc_ff;
        if (tx_complete_clear_wr || tx_complete_irq_ack) begin
            nxt_txc = 1'b0;                                         // [R11]
        end
        if (tx_done) begin
            nxt_txc = 1'b1;                                         // [R10]
        end
        nxt_eirq = buffer_empty_irq_enable & nxt_empty;             // [R8]
        nxt_cirq = tx_complete_irq_enable & nxt_txc;                // [R12]
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            tx_state_ff <= usd_pkg::TX_IDLE;
            tbuf_ff     <= usd_pkg::DATA_RST;
            tfull_ff    <= 1'b0;
            tsh_ff      <= usd_pkg::DATA_RST;
            tpar_ff     <= 1'b0;
            tidx_ff     <= 4'h0;
            tstop2_ff   <= 1'b0;
            txd_ff      <= 1'b1;
            txoe_ff     <= 1'b0;
            empty_ff    <= 1'b1;
            txc_ff      <= 1'b0;
            eirq_ff     <= 1'b0;
            cirq_ff     <= 1'b0;
        end else begin
            tx_state_ff <= nxt_tx_state;
            tbuf_ff     <= nxt_tbuf;
            tfull_ff    <= nxt_tfull;
            tsh_ff      <= nxt_tsh;
            tpar_ff     <= nxt_tpar;
            tidx_ff     <= nxt_tidx;
            tstop2_ff   <= nxt_tstop2;
            txd_ff      <= nxt_txd;
            txoe_ff     <= nxt_txoe;
            empty_ff    <= nxt_empty;
            txc_ff      <= nxt_txc;
            eirq_ff     <= nxt_eirq;
            cirq_ff     <= nxt_cirq;
        end
    end

    // ---------------- receiver ----------------
    // async mode samples mid-bit on the oversample count
    assign rsample = sync_mode ? rx_sync_sample
                               : (baud_os_tick && ros_ff == usd_pkg::OS_LAST); // [R16]

    always_comb begin
        nxt_rx_state = rx_state_ff;
        nxt_rsh      = rsh_ff;
        nxt_ridx     = ridx_ff;
        nxt_ros      = ros_ff;
        nxt_rbuf     = rbuf_ff;
        nxt_rxc      = rxc_ff;
        nxt_rxov     = receiver_enable_bit;                         // [R15]
        if (data_rd) begin
            nxt_rxc = 1'b0;
        end
        if (baud_os_tick) begin
            nxt_ros = ros_ff + 4'h1;
        end
        unique case (rx_state_ff)
            usd_pkg::RX_IDLE: begin
                nxt_rsh  = usd_pkg::DATA_RST;
                nxt_ridx = 4'h0;
                nxt_ros  = 4'h0;
                if (!rxd_s) begin
                    if (!sync_mode) begin
                        nxt_rx_state = usd_pkg::RX_START;
                    end else if (rx_sync_sample) begin
                        nxt_rx_state = usd_pkg::RX_DATA;            // [R17]
                    end
                end
            end
            usd_pkg::RX_START: begin
                // a low that is gone at mid start bit is a glitch
                if (baud_os_tick && ros_ff == usd_pkg::OS_MID) begin
                    nxt_ros      = 4'h0;
                    nxt_rx_state = rxd_s ? usd_pkg::RX_IDLE
                                         : usd_pkg::RX_DATA;        // [R17]
                end
            end
            usd_pkg::RX_DATA: begin
                if (rsample) begin
                    nxt_rsh[ridx_ff] = rxd_s;                       // [R17] [R20]
                    nxt_ridx         = ridx_ff + 4'h1;
                    if (ridx_ff + 4'h1 == nbits) begin
                        nxt_rx_state = parity_enable_bit ? usd_pkg::RX_PAR
                                                         : usd_pkg::RX_STOP;
                    end
                end
            end
            usd_pkg::RX_PAR: begin
                if (rsample) begin
                    nxt_rx_state = usd_pkg::RX_STOP;
                end
            end
            usd_pkg::RX_STOP: begin
                // second stop bit is not waited for
                if (rsample) begin
                    nxt_rbuf     = rsh_ff & dmask;                  // [R18] [R19] [R20]
                    nxt_rxc      = 1'b1;                            // [R25]
                    nxt_rx_state = usd_pkg::RX_IDLE;
                end
            end
            default: nxt_rx_state = usd_pkg::RX_IDLE;
        endcase
        // disabling is immediate and flushes the buffer
        if (!receiver_enable_bit) begin
            nxt_rx_state = usd_pkg::RX_IDLE;
            nxt_rxc      = 1'b0;                                    // [R25]
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rx_state_ff <= usd_pkg::RX_IDLE;
            rsh_ff      <= usd_pkg::DATA_RST;
            ridx_ff     <= 4'h0;
            ros_ff      <= 4'h0;
            rbuf_ff     <= usd_pkg::DATA_RST;
            rxc_ff      <= 1'b0;
            rxov_ff     <= 1'b0;
        end else begin
            rx_state_ff <= nxt_rx_state;
            rsh_ff      <= nxt_rsh;
            ridx_ff     <= nxt_ridx;
            ros_ff      <= nxt_ros;
            rbuf_ff     <= nxt_rbuf;
            rxc_ff      <= nxt_rxc;
            rxov_ff     <= nxt_rxov;
        end
    end

    assign txd_out              = txd_ff;
    assign txd_oe               = txoe_ff;
    assign rxd_override         = rxov_ff;
    assign tx_buffer_empty_flag = empty_ff;
    assign tx_complete_flag     = txc_ff;
    assign rx_complete_flag     = rxc_ff;
    assign buffer_empty_irq     = eirq_ff;
    assign tx_complete_irq      = cirq_ff;
    assign rx_data              = rbuf_ff[7:0];
    assign rx_ninth_bit         = rbuf_ff[8];

    // ---------------- checks ----------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    AST_TXD_IDLE_HIGH: assert property ( // [R26]
        txoe_ff && tx_state_ff == usd_pkg::TX_IDLE |-> txd_ff)
        else $error("transmit line not high while idle");
    AST_WRITE_CLEARS_EMPTY: assert property ( // [R7]
        data_wr |=> !empty_ff ##0 !tx_buffer_empty_flag)
        else $error("empty flag not cleared by data write");
    AST_EMPTY_IRQ_LEVEL: assert property ( // [R8]
        buffer_empty_irq_enable && empty_ff && !data_wr |=> eirq_ff [*1] or !empty_ff)
        else $error("empty interrupt dropped while flag set");
    AST_TXC_SET: assert property ( // [R10]
        tx_state_ff == usd_pkg::TX_FIN && tx_bit_en && !tfull_ff
        |=> txc_ff && tx_state_ff == usd_pkg::TX_IDLE)
        else $error("complete flag not set at frame end");
    AST_TXC_CLEAR: assert property ( // [R11]
        (tx_complete_clear_wr || tx_complete_irq_ack) && !tx_done |=> !txc_ff)
        else $error("complete flag not cleared");
    AST_START_LOW: assert property ( // [R23]
        tx_state_ff == usd_pkg::TX_START && tx_bit_en
        |=> !txd_ff && tx_state_ff == usd_pkg::TX_DATA && tidx_ff == 4'h0)
        else $error("start bit not driven low");
    AST_PARITY_BIT: assert property ( // [R13]
        tx_state_ff == usd_pkg::TX_PAR && tx_bit_en
        |=> txd_ff == $past(tpar_ff) && tx_state_ff == usd_pkg::TX_STOP)
        else $error("parity bit wrong or misplaced");
    // pin ownership is registered from next-state, so a busy shifter already shows it
    AST_DISABLE_WAITS: assert property ( // [R14]
        !transmitter_enable_bit && (tfull_ff || tx_state_ff != usd_pkg::TX_IDLE)
        |-> txoe_ff)
        else $error("transmit pin released before drain");
    AST_RX_UPPER_ZERO: assert property ( // [R20]
        rxc_ff && $stable(character_size_field) && $past(rx_state_ff) == usd_pkg::RX_STOP
        |-> (rbuf_ff & ~dmask) == usd_pkg::DATA_RST)
        else $error("unused received bits not zero");
    AST_RX_FLUSH: assert property ( // [R25]
        !receiver_enable_bit |=> !rxc_ff && rx_state_ff == usd_pkg::RX_IDLE)
        else $error("receive buffer not flushed");

    COV_TX_FRAME: cover property (tx_state_ff == usd_pkg::TX_FIN && tx_bit_en && !tfull_ff);
    COV_TX_BACK2BACK: cover property (tx_state_ff == usd_pkg::TX_FIN && tx_bit_en && tfull_ff);
    COV_RX_FRAME: cover property (rx_state_ff == usd_pkg::RX_STOP && rsample);
    COV_RX_GLITCH: cover property (rx_state_ff == usd_pkg::RX_START ##1 rx_state_ff == usd_pkg::RX_IDLE);

endmodule : usd_datapath

// >>> usd_remote_model.sv
// remote serial transceiver model for the data path bench
`timescale 1ns/1ps
module usd_remote_model #(
    parameter int BP = 32
) (
    input  wire logic       clk,
    input  wire logic       txd,
    input  wire logic       oe,
    input  wire logic [3:0] nb,
    input  wire logic       pe,
    output logic            rxd,
    output logic [8:0]      word,
    output logic            par,
    output logic            stp,
    output int              cnt
);
    initial begin
        rxd = 1'b1;
        cnt = 0;
    end
    // decode at mid bit so a few cycles of launch latency do not matter
    always begin
        @(negedge txd iff oe);
        repeat (BP / 2) @(posedge clk);
        word = 9'h000;
        for (int i = 0; i < nb; i++) begin
            repeat (BP) @(posedge clk);
            word[i] = txd;
        end
        if (pe) begin
            repeat (BP) @(posedge clk);
            par = txd;
        end
        repeat (BP) @(posedge clk);
        stp = txd;
        cnt++;
    end
    task automatic send(input logic [8:0] d, input logic p);
        @(posedge clk) rxd <= 1'b0;
        for (int i = 0; i < nb; i++) begin
            repeat (BP) @(posedge clk);
            rxd <= d[i];
        end
        if (pe) begin
            repeat (BP) @(posedge clk);
            rxd <= p;
        end
        repeat (BP) @(posedge clk);
        rxd <= 1'b1;
        repeat (BP) @(posedge clk);
    endtask : send
endmodule : usd_remote_model

// >>> usd_datapath_tb.sv
// self-checking bench for the serial data path
`timescale 1ns/1ps
module usd_datapath_tb;
    logic       clk = 0, resetn = 0, tick = 0, ten = 0, ren = 0, pe = 0, po = 0;
    logic       sbs = 0, beie = 0, tcie = 0, bed = 0, tcd = 0, n9 = 0, wr = 0;
    logic       rd = 0, tclr = 0, tack = 0, rxd, txd, oe, rxov, bef, tcf, rcf, bei, tci, rx9;
    logic [2:0] csz = 3'h3;
    logic [7:0] wd = 8'h00, rxq;
    logic [8:0] msk = 9'h0FF, word, wv, rv, exp_q[$];
    logic [3:0] nb = 4'h8;
    logic       par, stp;
    int         cnt, error_cnt = 0, checked = 0;
    always #20 clk = ~clk;
    // os tick every other cycle keeps a bit at 32 clocks
    always @(posedge clk) tick <= ~tick;
    always @(posedge clk) {bed, tcd} <= {beie, tcie};
    usd_datapath i_usd_datapath (.clk(clk), .resetn(resetn), .baud_os_tick(tick),
        .sync_mode(1'b0), .xck_polarity(1'b0), .transmitter_enable_bit(ten),
        .receiver_enable_bit(ren), .character_size_field(csz), .parity_enable_bit(pe),
        .parity_odd_select(po), .stop_bits_select(sbs), .buffer_empty_irq_enable(beie),
        .tx_complete_irq_enable(tcie), .tx_ninth_bit(n9), .data_wr(wr), .data_wdata(wd),
        .data_rd(rd), .tx_complete_clear_wr(tclr), .tx_complete_irq_ack(tack),
        .xck_pin_in(1'b0), .rxd_pin_in(rxd), .txd_out(txd), .txd_oe(oe),
        .rxd_override(rxov), .tx_buffer_empty_flag(bef), .tx_complete_flag(tcf),
        .rx_complete_flag(rcf), .buffer_empty_irq(bei), .tx_complete_irq(tci),
        .rx_data(rxq), .rx_ninth_bit(rx9));
    usd_remote_model #(.BP(32)) i_usd_remote_model (.clk(clk), .txd(txd), .oe(oe),
        .nb(nb), .pe(pe), .rxd(rxd), .word(word), .par(par), .stp(stp), .cnt(cnt));
    task automatic chk(input logic [8:0] a, input logic [8:0] e);
        checked++;
        if (a !== e) begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, a, e);
        end
    endtask : chk
    task automatic stop_test();
        $display("errors %0d checks %0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    task automatic put(input logic [8:0] d);
        @(posedge clk) {wr, n9, wd} <= {1'b1, d};
        exp_q.push_back(d & msk);
        @(posedge clk) wr <= 1'b0;
        #1 chk(bef, 1'b0);
    endtask : put
    // irq outputs are registered together with their flags
    always @(negedge clk) if (resetn) begin
        chk(bei, bed & bef);
        chk(tci, tcd & tcf);
    end
    always @(cnt) if (cnt > 0) begin
        wv = exp_q.pop_front();
        chk(word, wv);
        chk(stp, 1'b1);
        if (pe) chk(par, ^wv ^ po);
    end
    initial begin
        #2400000;
        error_cnt++;
        stop_test();
    end
    initial begin
        void'($urandom(32'h6E66));
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk) {ten, ren} <= 2'b11;
        #1 chk(bef, 1'b1);
        for (int s = 0; s < 15; s++) begin
            @(posedge clk) {beie, tcie, sbs} <= 3'($urandom);
            csz <= (s / 3 == 4) ? 3'h7 : 3'(s / 3);
            {pe, po} <= {s % 3 != 0, s % 3 == 2};
            nb = (s / 3 == 4) ? 4'h9 : 4'(s / 3 + 5);
            msk = 9'((10'h001 << nb) - 10'h001);
            repeat (3) @(posedge clk);
            #1 chk(txd, 1'b1);
            chk({rxov, oe}, 2'b11);
            rv = 9'($urandom) & msk;
            fork
                begin
                    put(9'($urandom));
                    for (int k = 0; k < 3000 && tcf !== 1'b1; k++) @(posedge clk);
                    chk(tcf, 1'b1);
                    @(posedge clk) {tack, tclr} <= s[0] ? 2'b10 : 2'b01;
                    @(posedge clk) {tack, tclr} <= 2'b00;
                    #1 chk(tcf, 1'b0);
                end
                begin
                    i_usd_remote_model.send(rv, ^rv ^ po);
                    for (int k = 0; k < 3000 && rcf !== 1'b1; k++) @(posedge clk);
                    chk({rx9, rxq}, rv);
                    @(posedge clk) rd <= 1'b1;
                    @(posedge clk) rd <= 1'b0;
                    #1 chk(rcf, 1'b0);
                end
            join
        end
        put(9'($urandom));
        put(9'($urandom));
        @(posedge clk) {ten, ren} <= 2'b00;
        for (int k = 0; k < 3000 && tcf !== 1'b1; k++) begin
            @(posedge clk) #1 if (tcf !== 1'b1) chk(oe, 1'b1);
        end
        repeat (3) @(posedge clk);
        chk({oe, rxov, exp_q.size() == 0}, 3'b001);
        stop_test();
    end
endmodule : usd_datapath_tb
